// *** rtl/spio_port.sv ***
// Shared parallel I/O port: registers, read path and registered pin controls.
// Assumes a one-cycle strobe register port and same-clock peripheral signals.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns

module spio_port
    import spio_pkg::*;
#(
    parameter bit WIDE_PACKAGE = 1'b1
)
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              low_power,
    input  wire logic [PIN_W-1:0]  alt_dig_en,
    input  wire logic [PIN_W-1:0]  alt_ana_en,
    input  wire logic [PIN_W-1:0]  alt_oe,
    input  wire logic [PIN_W-1:0]  alt_out,
    input  wire logic              dbg_oe,
    input  wire logic              dbg_out,
    input  wire logic [PIN_W-1:0]  pin_i,
    output logic      [PIN_W-1:0]  pin_o,
    output logic      [PIN_W-1:0]  pin_oe_n,
    output logic      [PIN_W-1:0]  pin_ie,
    output logic      [PIN_W-1:0]  pin_pull_en,
    output logic      [PIN_W-1:0]  pin_pull_dn,
    output logic      [PIN_W-1:0]  pin_slew_en,
    output logic      [PIN_W-1:0]  pin_in_level
);
    // Narrow package has no pins 4 and 5
    localparam logic [PIN_W-1:0] PRESENT = WIDE_PACKAGE ? 6'h3f : ~WIDE_ONLY;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    spio_pin_if pif ();

    logic [PIN_W-1:0]  pin_sync;
    logic [PIN_W-1:0]  data_r;
    logic [PIN_W-1:0]  data_nxt;
    logic [PIN_W-1:0]  dir_r;
    logic [PIN_W-1:0]  dir_nxt;
    logic [PIN_W-1:0]  pe_r;
    logic [PIN_W-1:0]  pe_nxt;
    logic [PIN_W-1:0]  pud_r;
    logic [PIN_W-1:0]  pud_nxt;
    logic [PIN_W-1:0]  slew_r;
    logic [PIN_W-1:0]  slew_nxt;
    logic [PIN_W-1:0]  dig_r;
    logic [PIN_W-1:0]  dig_nxt;
    logic [PIN_W-1:0]  ana_r;
    logic [PIN_W-1:0]  ana_nxt;
    logic              dbgfn_r;
    logic              dbgfn_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [PIN_W-1:0]  o_r;
    logic [PIN_W-1:0]  o_nxt;
    logic [PIN_W-1:0]  oen_r;
    logic [PIN_W-1:0]  oen_nxt;
    logic [PIN_W-1:0]  ie_r;
    logic [PIN_W-1:0]  ie_nxt;
    logic [PIN_W-1:0]  pu_r;
    logic [PIN_W-1:0]  pu_nxt;
    logic [PIN_W-1:0]  pd_r;
    logic [PIN_W-1:0]  pd_nxt;
    logic [PIN_W-1:0]  sl_r;
    logic [PIN_W-1:0]  sl_nxt;
    logic [PIN_W-1:0]  lvl_r;
    logic [PIN_W-1:0]  lvl_nxt;
    logic [PIN_W-1:0]  rd_bits;
    logic [PIN_W-1:0]  wbits;

    spio_sync #(.W(PIN_W)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       (pin_i),
        .q       (pin_sync)
    );

    spio_arb u_arb (
        .p (pif.arb)
    );

    // Owner and drive inputs to the arbiter
    always_comb
    begin
        pif.dig_own = dig_r;
        pif.dig_own[OUT_ONLY_PIN] = dbgfn_r;
        pif.ana_own = ana_r;
        pif.dir_eff = (dir_r & DIR_MASK & PRESENT);
        pif.dir_eff[OUT_ONLY_PIN] = 1'b1;
        pif.data = data_r;
        pif.pull_en_sel = pe_r & CTRL_MASK & PRESENT;
        pif.pull_dn_sel = pud_r & CTRL_MASK & PRESENT;
        pif.alt_oe = alt_oe;
        pif.alt_oe[IN_ONLY_PIN] = 1'b0;
        pif.alt_oe[OUT_ONLY_PIN] = dbg_oe;
        pif.alt_out = alt_out;
        pif.alt_out[OUT_ONLY_PIN] = dbg_out;
    end

    // Read source per bit: latch for outputs, gated pin level for inputs
    always_comb
    begin
        for (int i = 0; i < PIN_W; i++)
        begin
            if (pif.dir_eff[i])
                rd_bits[i] = data_r[i];
            else
                rd_bits[i] = pif.in_en[i] & pin_sync[i];
        end
        rd_bits = rd_bits & PRESENT;
    end

    // Register file next state
    always_comb
    begin
        wbits     = reg_wdata[PIN_W-1:0];
        data_nxt  = data_r;
        dir_nxt   = dir_r;
        pe_nxt    = pe_r;
        pud_nxt   = pud_r;
        slew_nxt  = slew_r;
        dbgfn_nxt = dbgfn_r;
        if (reg_wr)
        begin
            if (hit(reg_addr, OFF_DATA))
                data_nxt = wbits;
            else if (hit(reg_addr, OFF_DIR))
                dir_nxt = wbits & DIR_MASK & PRESENT;
            else if (hit(reg_addr, OFF_PULL_EN))
                pe_nxt = wbits & CTRL_MASK & PRESENT;
            else if (hit(reg_addr, OFF_PULL_SEL))
                pud_nxt = wbits & CTRL_MASK & PRESENT;
            else if (hit(reg_addr, OFF_SLEW))
                slew_nxt = wbits & CTRL_MASK & PRESENT;
            else if (hit(reg_addr, OFF_FUNC))
                dbgfn_nxt = reg_wdata[FUNC_DBG_BIT];
        end
    end

    // Shared enables are sampled; a peripheral still held in reset reads off
    always_comb
    begin
        dig_nxt   = alt_dig_en & PRESENT;
        dig_nxt[IN_ONLY_PIN] = 1'b0;
        ana_nxt   = alt_ana_en & PRESENT;
    end

    // Read data stands one cycle, zero otherwise
    always_comb
    begin
        rdata_nxt = RST_RDATA;
        if (reg_rd)
        begin
            if (hit(reg_addr, OFF_DATA))
                rdata_nxt = {2'b00, rd_bits};
            else if (hit(reg_addr, OFF_DIR))
                rdata_nxt = {2'b00, dir_r};
            else if (hit(reg_addr, OFF_PULL_EN))
                rdata_nxt = {2'b00, pe_r};
            else if (hit(reg_addr, OFF_PULL_SEL))
                rdata_nxt = {2'b00, pud_r};
            else if (hit(reg_addr, OFF_SLEW))
                rdata_nxt = {2'b00, slew_r};
            else if (hit(reg_addr, OFF_FUNC))
                rdata_nxt = {7'h00, dbgfn_r};
            else if (hit(reg_addr, OFF_OWNER))
                rdata_nxt = {2'b00, pif.ana_own | pif.dig_own};
            else
                rdata_nxt = RST_RDATA;
        end
    end

    // Pin controls frozen while in wait or stop; input level sampled throughout
    always_comb
    begin
        o_nxt   = o_r;
        oen_nxt = oen_r;
        ie_nxt  = ie_r;
        pu_nxt  = pu_r;
        pd_nxt  = pd_r;
        sl_nxt  = sl_r;
        lvl_nxt = pin_sync & ie_r;
        if (!low_power)
        begin
            o_nxt   = pif.level & PRESENT;
            oen_nxt = ~(pif.drive & PRESENT);
            ie_nxt  = pif.in_en & PRESENT;
            pu_nxt  = pif.pull_on;
            pd_nxt  = pif.pull_on & pif.pull_dn;
            sl_nxt  = slew_r & CTRL_MASK & PRESENT;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            data_r  <= RST_DATA;
            dir_r   <= RST_DIR;
            pe_r    <= RST_PULL_EN;
            pud_r   <= RST_PULL_SEL;
            slew_r  <= RST_SLEW;
            dbgfn_r <= RST_DBG_FN;
        end
        else
        begin
            data_r  <= data_nxt;
            dir_r   <= dir_nxt;
            pe_r    <= pe_nxt;
            pud_r   <= pud_nxt;
            slew_r  <= slew_nxt;
            dbgfn_r <= dbgfn_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            dig_r   <= RST_OWN;
            ana_r   <= RST_OWN;
        end
        else
        begin
            dig_r   <= dig_nxt;
            ana_r   <= ana_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rdata_r <= RST_RDATA;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            o_r     <= RST_DATA;
            oen_r   <= '1;
            ie_r    <= '0;
            pu_r    <= '0;
            pd_r    <= '0;
            sl_r    <= '0;
            lvl_r   <= '0;
        end
        else
        begin
            o_r     <= o_nxt;
            oen_r   <= oen_nxt;
            ie_r    <= ie_nxt;
            pu_r    <= pu_nxt;
            pd_r    <= pd_nxt;
            sl_r    <= sl_nxt;
            lvl_r   <= lvl_nxt;
        end
    end

    assign reg_rdata    = rdata_r;
    assign pin_o        = o_r;
    assign pin_oe_n     = oen_r;
    assign pin_ie       = ie_r;
    assign pin_pull_en  = pu_r;
    assign pin_pull_dn  = pd_r;
    assign pin_slew_en  = sl_r;
    assign pin_in_level = lvl_r;
endmodule : spio_port

// *** rtl/spio_pkg.sv ***
// Constants for the shared parallel I/O port: widths, offsets, masks, resets.
// Assumes an 8-bit register port on the system clock; pin 2 in, pin 3 out.
package spio_pkg;
    localparam int          PIN_W         = 6;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam int          SYNC_STAGES   = 2;
    // Data and direction stay inside the short-addressing window
    localparam logic [7:0]  SHORT_LIMIT   = 8'h1f;
    localparam logic [7:0]  OFF_DATA      = 8'h00;
    localparam logic [7:0]  OFF_DIR       = 8'h01;
    localparam logic [7:0]  OFF_PULL_EN   = 8'h20;
    localparam logic [7:0]  OFF_PULL_SEL  = 8'h21;
    localparam logic [7:0]  OFF_SLEW      = 8'h22;
    localparam logic [7:0]  OFF_FUNC      = 8'h23;
    localparam logic [7:0]  OFF_OWNER     = 8'h24;
    localparam int          FUNC_DBG_BIT  = 0;
    localparam int          OUT_ONLY_PIN  = 3;
    localparam int          IN_ONLY_PIN   = 2;
    localparam logic [5:0]  DIR_MASK      = 6'h33;
    localparam logic [5:0]  CTRL_MASK     = 6'h37;
    localparam logic [5:0]  WIDE_ONLY     = 6'h30;
    localparam logic [5:0]  RST_DATA      = 6'h00;
    localparam logic [5:0]  RST_DIR       = 6'h00;
    localparam logic [5:0]  RST_PULL_EN   = 6'h00;
    localparam logic [5:0]  RST_PULL_SEL  = 6'h00;
    localparam logic [5:0]  RST_SLEW      = 6'h00;
    localparam logic [5:0]  RST_OWN       = 6'h00;
    localparam logic        RST_DBG_FN    = 1'b1;
    localparam logic [7:0]  RST_RDATA     = 8'h00;
endpackage : spio_pkg

// *** rtl/spio_pin_if.sv ***
// Per-pin control bundle between the register core and the pin arbiter.
// Assumes both ends run on the same clock; all signals are combinational.
`timescale 1ns/1ns
interface spio_pin_if;
    import spio_pkg::*;
    logic [PIN_W-1:0] dig_own;
    logic [PIN_W-1:0] ana_own;
    logic [PIN_W-1:0] dir_eff;
    logic [PIN_W-1:0] data;
    logic [PIN_W-1:0] pull_en_sel;
    logic [PIN_W-1:0] pull_dn_sel;
    logic [PIN_W-1:0] alt_oe;
    logic [PIN_W-1:0] alt_out;
    logic [PIN_W-1:0] drive;
    logic [PIN_W-1:0] level;
    logic [PIN_W-1:0] in_en;
    logic [PIN_W-1:0] pull_on;
    logic [PIN_W-1:0] pull_dn;
    modport ctl (output dig_own, ana_own, dir_eff, data, pull_en_sel, pull_dn_sel,
                 alt_oe, alt_out, input drive, level, in_en, pull_on, pull_dn);
    modport arb (input dig_own, ana_own, dir_eff, data, pull_en_sel, pull_dn_sel,
                 alt_oe, alt_out, output drive, level, in_en, pull_on, pull_dn);
endinterface : spio_pin_if

// *** rtl/spio_sync.sv ***
// Two-flop synchroniser for pin levels entering the system clock domain.
// Assumes asynchronous pin inputs; first stage feeds only the second.
`timescale 1ns/1ns
module spio_sync
    import spio_pkg::*;
#(
    parameter int W = PIN_W
)
(
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            meta_r <= '0;
            q_r    <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : spio_sync

// *** rtl/spio_arb.sv ***
// Pin ownership arbiter: analog over shared digital over the port itself.
// Assumes the controller supplies owner, direction and data bits per pin.
`timescale 1ns/1ns
module spio_arb
    import spio_pkg::*;
(
    spio_pin_if.arb p
);
    for (genvar i = 0; i < PIN_W; i++)
    begin : g_pin
        logic ana;
        logic dig;
        assign ana = p.ana_own[i];
        assign dig = p.dig_own[i] & ~ana;
        // Analog kills both buffers
        assign p.drive[i] = ana ? 1'b0 : (dig ? p.alt_oe[i] : p.dir_eff[i]);
        assign p.level[i] = dig ? p.alt_out[i] : p.data[i];
        assign p.in_en[i] = ~ana && (i != OUT_ONLY_PIN);
        // Pull only on an undriven digital pin
        assign p.pull_on[i] = p.pull_en_sel[i] & ~p.drive[i] & ~ana;
        assign p.pull_dn[i] = p.pull_dn_sel[i];
    end
endmodule : spio_arb

// *** tb/spio_port_assertions.sv ***
// Concurrent checks on the shared parallel I/O port's top-level ports.
// Assumes the bench keeps shared-function and power inputs low in reset.
`timescale 1ns/1ns
module spio_port_checker
    import spio_pkg::*;
#(
    parameter bit WIDE_PACKAGE = 1'b1
)
(
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              low_power,
    input wire logic [PIN_W-1:0]  alt_dig_en,
    input wire logic [PIN_W-1:0]  alt_ana_en,
    input wire logic [PIN_W-1:0]  alt_oe,
    input wire logic [PIN_W-1:0]  alt_out,
    input wire logic              dbg_oe,
    input wire logic              dbg_out,
    input wire logic [PIN_W-1:0]  pin_i,
    input wire logic [PIN_W-1:0]  pin_o,
    input wire logic [PIN_W-1:0]  pin_oe_n,
    input wire logic [PIN_W-1:0]  pin_ie,
    input wire logic [PIN_W-1:0]  pin_pull_en,
    input wire logic [PIN_W-1:0]  pin_pull_dn,
    input wire logic [PIN_W-1:0]  pin_slew_en,
    input wire logic [PIN_W-1:0]  pin_in_level
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // Owner register then pin register: two edges from cause to pad
    chk_ana_owns_pin: assert property (
        !$past(low_power) |-> ((pin_ie | ~pin_oe_n | pin_pull_en) & $past(alt_ana_en, 2)) == '0)
        else $error("analog pin not released");
    chk_read_one_cycle: assert property (
        reg_rdata != '0 |-> $past(reg_rd)) else $error("read data outside its cycle");
    chk_pull_off_out: assert property (
        (pin_pull_en & ~pin_oe_n) == '0) else $error("pull left on a driven pin");
    chk_dir_drives_pin: assert property (
        reg_wr && reg_addr == OFF_DIR && (alt_dig_en[1:0] | alt_ana_en[1:0]) == 2'b00
        ##1 !low_power |=> pin_oe_n[1:0] == ~$past(reg_wdata[1:0], 2))
        else $error("direction bit not on output enable");
    chk_dig_drives_oe: assert property (
        alt_dig_en[1] && !alt_ana_en[1] ##1 !low_power && $stable(alt_oe[1])
        |=> pin_oe_n[1] == !$past(alt_oe[1])) else $error("digital owner not on enable");
    chk_sleep_holds: assert property (
        $past(low_power) |-> $stable(pin_oe_n) && $stable(pin_o) && $stable(pin_ie))
        else $error("pin state moved in low power");
    chk_in_level_lag: assert property (
        (pin_in_level & ~$past(pin_i, 3)) == '0) else $error("input level without cause");
    chk_pin_kinds: assert property (
        pin_oe_n[IN_ONLY_PIN] && !pin_ie[OUT_ONLY_PIN]) else $error("fixed pin misused");
endmodule : spio_port_checker

bind spio_port spio_port_checker #(.WIDE_PACKAGE(WIDE_PACKAGE)) u_chk (.*);

// *** tb/spio_pin_model.sv ***
// Pad model for the shared port: resolves each line from all its drivers.
// Assumes the bench supplies one external driver per pin.
`timescale 1ns/1ns
module spio_pin_model
    import spio_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic [PIN_W-1:0] pin_o,
    input  wire logic [PIN_W-1:0] pin_oe_n,
    input  wire logic [PIN_W-1:0] pin_pull_en,
    input  wire logic [PIN_W-1:0] pin_pull_dn,
    input  wire logic [PIN_W-1:0] ext_en,
    input  wire logic [PIN_W-1:0] ext_val,
    output logic      [PIN_W-1:0] pin_i
);
    logic flt_r = 1'b0;
    // Undriven lines wander so a stale level never passes for a real one
    always @(posedge clk_sys) flt_r <= ~flt_r;
    always_comb
    begin
        for (int k = 0; k < PIN_W; k++)
        begin
            if (!pin_oe_n[k])
                pin_i[k] = pin_o[k];
            else if (ext_en[k])
                pin_i[k] = ext_val[k];
            else if (pin_pull_en[k])
                pin_i[k] = ~pin_pull_dn[k];
            else
                pin_i[k] = flt_r ^ k[0];
        end
    end
endmodule : spio_pin_model

// *** tb/shared_parallel_io_port_bench.sv ***
// Bench for spio_port: register tasks, pad model and directed scenarios.
// Assumes pins follow register writes one edge late and owners two.
`timescale 1ns/1ns
module shared_parallel_io_port_bench
    import spio_pkg::*;
;
    logic              clk_sys;
    logic              reset;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic              reg_wr, reg_rd, low_power, dbg_oe, dbg_out;
    logic [PIN_W-1:0]  alt_dig_en, alt_ana_en, alt_oe, alt_out, ext_en, ext_val;
    logic [PIN_W-1:0]  pin_i, pin_o, pin_oe_n, pin_ie, pin_pull_en, pin_pull_dn;
    logic [PIN_W-1:0]  pin_slew_en, pin_in_level;
    int                n_mismatch = 0;
    int                n_compared = 0;

    spio_port #(.WIDE_PACKAGE(1'b1)) dut (.*);
    spio_pin_model model (.*);

    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, want);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle
    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial
    begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        {reset, reg_wr, reg_rd, low_power, dbg_oe, dbg_out} = 6'b100000;
        {reg_addr, reg_wdata} = 16'h0000;
        {alt_dig_en, alt_ana_en, alt_oe, alt_out} = 24'h000000;
        ext_en  = 6'h3f;
        ext_val = 6'h25;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        settle(2);
        chk({2'h0, pin_oe_n}, 8'h3f);
        chk({2'h0, pin_ie}, 8'h37);
        chk({2'h0, pin_pull_en}, 8'h00);
        chk({2'h0, pin_o}, 8'h00);
        chk({6'h0, OFF_DATA <= SHORT_LIMIT, OFF_DIR <= SHORT_LIMIT}, 8'h03);
        rd(OFF_DATA, 8'h25);
        rd(OFF_DIR, 8'h00);
        rd(OFF_FUNC, 8'h01);
        rd(OFF_OWNER, 8'h08);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        // Data first so the pads never show a stale value
        wr(OFF_DATA, 8'h3a);
        wr(OFF_DIR, 8'hff);
        settle(1);
        chk({2'h0, pin_oe_n}, 8'h0c);
        chk({2'h0, pin_o & DIR_MASK}, 8'h32);
        rd(OFF_DIR, 8'h33);
        rd(OFF_DATA, 8'h3e);
        @(posedge clk_sys);
        low_power <= 1'b1;
        wr(OFF_DIR, 8'h00);
        settle(2);
        chk({2'h0, pin_oe_n}, 8'h0c);
        @(posedge clk_sys);
        low_power <= 1'b0;
        settle(4);
        chk({2'h0, pin_oe_n}, 8'h3f);
        rd(OFF_DATA, 8'h2d);
        @(posedge clk_sys);
        alt_ana_en <= 6'h01;
        alt_dig_en <= 6'h03;
        alt_oe     <= 6'h03;
        alt_out    <= 6'h02;
        settle(4);
        chk({2'h0, pin_ie}, 8'h36);
        chk({2'h0, pin_oe_n}, 8'h3d);
        chk({7'h0, pin_o[1]}, 8'h01);
        rd(OFF_DATA, 8'h2e);
        @(posedge clk_sys);
        alt_ana_en <= 6'h00;
        alt_dig_en <= 6'h00;
        ext_en     <= 6'h00;
        wr(OFF_PULL_EN, 8'hff);
        wr(OFF_PULL_SEL, 8'h01);
        wr(OFF_DIR, 8'h10);
        settle(1);
        chk({2'h0, pin_pull_en}, 8'h27);
        chk({2'h0, pin_pull_dn}, 8'h01);
        settle(3);
        rd(OFF_DATA, 8'h3e);
        rd(OFF_PULL_EN, 8'h37);
        chk({2'h0, pin_in_level}, 8'h36);
        wr(OFF_SLEW, 8'hff);
        settle(1);
        chk({2'h0, pin_slew_en}, 8'h37);
        @(posedge clk_sys);
        dbg_oe  <= 1'b1;
        dbg_out <= 1'b1;
        settle(3);
        chk({2'h0, pin_oe_n}, 8'h27);
        chk({7'h0, pin_o[3]}, 8'h01);
        @(posedge clk_sys);
        dbg_out <= 1'b0;
        wr(OFF_FUNC, 8'h00);
        settle(2);
        chk({7'h0, pin_o[3]}, 8'h01);
        wrap_up();
    end
endmodule : shared_parallel_io_port_bench
